// File: core/quad_pot_regs.svh
// constants for the quad wiper serial slave: address, command codes, sizes
// assumes inclusion by the package, design and testbench files of this block
`ifndef QUAD_POT_REGS_SVH
`define QUAD_POT_REGS_SVH

// fixed upper nibble of the slave address (value arbitrary)
`define QP_SLAVE_ID     4'h5
`define QP_ADDR_BITS    4
`define QP_POT_COUNT    4
`define QP_STORED_COUNT 4
`define QP_POS_BITS     6
`define QP_TAP_COUNT    64
// command byte: opcode in bits 7:4, pot in 3:2, stored index in 1:0
`define QP_OP_RD_WIPER  4'h9
`define QP_OP_WR_WIPER  4'ha
`define QP_OP_RD_STORED 4'hb
`define QP_OP_WR_STORED 4'hc
`define QP_OP_XFER      4'hd
// content of the stored-position registers before any write
`define QP_STORED_RESET 6'h20
`define QP_ACK_BIT      4'h8

`endif

// File: core/quad_pot_pkg.sv
// types for the quad wiper serial slave
// assumes the constants header sits beside it
`include "quad_pot_regs.svh"

package quad_pot_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_WDATA,
      ST_RDATA,
      ST_DONE
   } bus_state_type;

   typedef struct packed {
      logic [3:0] opcode;
      logic [1:0] pot;
      logic [1:0] idx;
   } cmd_type;

   // pin group that is synchronised together
   typedef struct packed {
      logic                     scl;
      logic                     sda;
      logic                     wp_n;
      logic [`QP_ADDR_BITS-1:0] addr;
   } pins_type;

endpackage

// File: core/pot_tap_decoder.sv
// one-hot tap select for a single resistor array
// assumes a position that is stable in the MCLK domain
`timescale 1ns/1ps
`include "quad_pot_regs.svh"

module pot_tap_decoder #(
   parameter int POS_BITS = `QP_POS_BITS,
   parameter int TAPS     = `QP_TAP_COUNT
) (
   input  wire logic                clk,   // block clock
   input  wire logic                rst,   // async reset, high
   input  wire logic [POS_BITS-1:0] pos,   // wiper position
   output logic      [TAPS-1:0]     taps   // exactly one bit high
);

   logic [TAPS-1:0] taps_d;

   // decode, registered so the switches never see a glitch
   always_comb begin
      taps_d      = '0;
      taps_d[pos] = 1'b1;
   end

   // reset closes tap 0, so one switch is closed even during reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         taps <= {{(TAPS-1){1'b0}}, 1'b1};
      end else begin
         taps <= taps_d;
      end
   end

endmodule

// File: core/quad_pot_wiper_serial_slave.sv
// two-wire serial slave driving four 64-tap wipers
// assumes an external master owning SCL and a pull-up on SDA
`timescale 1ns/1ps
`include "quad_pot_regs.svh"

module quad_pot_wiper_serial_slave
   import quad_pot_pkg::*;
#(
   parameter int POTS = `QP_POT_COUNT,
   parameter int TAPS = `QP_TAP_COUNT
) (
   input  wire logic                     MCLK,      // 125 MHz block clock
   input  wire logic                     SYS_RST,   // async reset, high
   input  wire logic                     SCL,       // serial clock from master
   input  wire logic                     SDA_IN,    // serial data line level
   output logic                          SDA_OUT,   // always low, open drain
   output logic                          SDA_OE,    // high while pulling SDA low
   input  wire logic [`QP_ADDR_BITS-1:0] ADDR_SEL,  // address select pins
   input  wire logic                     WP_N,      // write protect, low blocks stored-slot writes
   output logic      [POTS*TAPS-1:0]     TAP_SEL    // one-hot taps, pot 0 lowest
);

   localparam int PB = `QP_POS_BITS;

   pins_type      pins_in;
   pins_type      sync1_q, sync2_q, prev_q;
   bus_state_type st_q, st_d, nxt_q, nxt_d;
   logic [3:0]    bit_q, bit_d;
   logic [7:0]    sh_q, sh_d;
   logic          ack_q, ack_d;
   logic          oe_q, oe_d;
   logic          load_q;
   cmd_type       cmd_q, cmd_d, cmd_in;
   logic [PB-1:0] wiper_q [POTS];
   logic [PB-1:0] wiper_d [POTS];
   logic [PB-1:0] stored_q [POTS*`QP_STORED_COUNT];
   logic [PB-1:0] stored_d [POTS*`QP_STORED_COUNT];
   logic [PB-1:0] rd_val;
   logic          scl_rise, scl_fall, start_ev, stop_ev;

   assign pins_in = '{scl: SCL, sda: SDA_IN, wp_n: WP_N, addr: ADDR_SEL};

   // two-stage synchroniser; only the second stage feeds logic
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sync1_q <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b0, addr: '0};
         sync2_q <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b0, addr: '0};
         prev_q  <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b0, addr: '0};
      end else begin
         sync1_q <= pins_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // line events; SCL and SDA share the same sync delay so ordering holds
   assign scl_rise = sync2_q.scl & ~prev_q.scl;
   assign scl_fall = ~sync2_q.scl & prev_q.scl;
   assign start_ev = sync2_q.scl & prev_q.scl & prev_q.sda & ~sync2_q.sda;
   assign stop_ev  = sync2_q.scl & prev_q.scl & ~prev_q.sda & sync2_q.sda;
   assign cmd_in   = cmd_type'(sh_q);

   // read source: wiper or one stored slot of the addressed pot
   always_comb begin
      if (cmd_q.opcode == `QP_OP_RD_WIPER) begin
         rd_val = wiper_q[cmd_q.pot];
      end else begin
         rd_val = stored_q[{cmd_q.pot, cmd_q.idx}];
      end
   end

   // protocol engine and register updates
   always_comb begin
      st_d     = st_q;
      nxt_d    = nxt_q;
      bit_d    = bit_q;
      sh_d     = sh_q;
      ack_d    = ack_q;
      oe_d     = oe_q;
      cmd_d    = cmd_q;
      wiper_d  = wiper_q;
      stored_d = stored_q;
      // power-up recall, one cycle after reset release
      if (load_q) begin
         for (int p = 0; p < POTS; p++) begin
            wiper_d[p] = stored_q[p*`QP_STORED_COUNT];
         end
      end
      if (start_ev) begin
         // a repeated start also lands here and restarts the address phase
         st_d  = ST_ADDR;
         bit_d = '0;
         ack_d = 1'b0;
         oe_d  = 1'b0;
      end else if (stop_ev) begin
         st_d  = ST_IDLE;
         bit_d = '0;
         ack_d = 1'b0;
         oe_d  = 1'b0;
      end else if (st_q != ST_IDLE && st_q != ST_DONE) begin
         if (scl_rise && !ack_q && bit_q < `QP_ACK_BIT) begin
            // data is sampled on the rising edge, stable while SCL high
            if (st_q != ST_RDATA) begin
               sh_d = {sh_q[6:0], sync2_q.sda};
            end
            bit_d = 4'(bit_q + 4'h1);
         end else if (scl_fall) begin
            // every SDA change is made just after SCL falls
            if (ack_q) begin
               // end of the ninth clock: let go and move on
               ack_d = 1'b0;
               oe_d  = 1'b0;
               bit_d = '0;
               st_d  = nxt_q;
               if (st_q != ST_RDATA && nxt_q == ST_RDATA) begin
                  sh_d = {2'b00, rd_val};
                  oe_d = ~sh_d[7];
               end
            end else if (st_q == ST_RDATA) begin
               if (bit_q == `QP_ACK_BIT) begin
                  // master acknowledge slot; one byte per read either way
                  oe_d  = 1'b0;
                  ack_d = 1'b1;
                  nxt_d = ST_DONE;
               end else if (bit_q != 4'h0) begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_d[7];
               end
            end else if (bit_q == `QP_ACK_BIT) begin
               case (st_q)
                  ST_ADDR: begin
                     if (sh_q == {`QP_SLAVE_ID, sync2_q.addr}) begin
                        oe_d  = 1'b1;
                        ack_d = 1'b1;
                        nxt_d = ST_CMD;
                     end else begin
                        st_d = ST_DONE;  // not ours: stay off the bus until next start
                     end
                  end
                  ST_CMD: begin
                     cmd_d = cmd_in;
                     oe_d  = 1'b1;
                     ack_d = 1'b1;
                     case (cmd_in.opcode)
                        `QP_OP_WR_WIPER, `QP_OP_WR_STORED: nxt_d = ST_WDATA;
                        `QP_OP_RD_WIPER, `QP_OP_RD_STORED: nxt_d = ST_RDATA;
                        `QP_OP_XFER: begin
                           nxt_d = ST_DONE;
                           wiper_d[cmd_in.pot] = stored_q[{cmd_in.pot, cmd_in.idx}];
                        end
                        default: begin
                           // unknown command gets no acknowledge
                           oe_d  = 1'b0;
                           ack_d = 1'b0;
                           st_d  = ST_DONE;
                        end
                     endcase
                  end
                  ST_WDATA: begin
                     oe_d  = 1'b1;
                     ack_d = 1'b1;
                     nxt_d = ST_DONE;
                     if (cmd_q.opcode == `QP_OP_WR_WIPER) begin
                        wiper_d[cmd_q.pot] = sh_q[PB-1:0];
                     end else if (sync2_q.wp_n) begin
                        stored_d[{cmd_q.pot, cmd_q.idx}] = sh_q[PB-1:0];
                     end
                  end
                  default: st_d = ST_DONE;
               endcase
            end
         end
      end
   end

   // state registers; stored slots model nonvolatile cells, reset is power-up
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_q   <= ST_IDLE;
         nxt_q  <= ST_IDLE;
         bit_q  <= '0;
         sh_q   <= '0;
         ack_q  <= 1'b0;
         oe_q   <= 1'b0;
         cmd_q  <= '0;
         load_q <= 1'b1;
         // wiper starts at tap 0, so only the recall can bring it to the stored value
         for (int p = 0; p < POTS; p++) begin
            wiper_q[p] <= '0;
         end
         for (int s = 0; s < POTS*`QP_STORED_COUNT; s++) begin
            stored_q[s] <= `QP_STORED_RESET;
         end
      end else begin
         st_q     <= st_d;
         nxt_q    <= nxt_d;
         bit_q    <= bit_d;
         sh_q     <= sh_d;
         ack_q    <= ack_d;
         oe_q     <= oe_d;
         cmd_q    <= cmd_d;
         load_q   <= 1'b0;
         wiper_q  <= wiper_d;
         stored_q <= stored_d;
      end
   end

   // open drain: the level is always low, only the enable moves
   assign SDA_OUT = 1'b0;
   assign SDA_OE  = oe_q;

   // one decoder per resistor array
   for (genvar g = 0; g < POTS; g++) begin : g_pot
      pot_tap_decoder #(
         .POS_BITS (PB),
         .TAPS     (TAPS)
      ) u_dec (
         .clk  (MCLK),
         .rst  (SYS_RST),
         .pos  (wiper_q[g]),
         .taps (TAP_SEL[g*TAPS +: TAPS])
      );
   end

endmodule

// File: bench/quad_pot_monitor.sv
// port checker for the quad wiper serial slave
// assumes binding onto the top module, one MCLK domain
`timescale 1ns/1ps

module quad_pot_monitor #(
   parameter int POTS = 4,
   parameter int TAPS = 64
) (
   input wire logic                 MCLK,     // block clock
   input wire logic                 SYS_RST,  // async reset
   input wire logic                 SCL,      // serial clock
   input wire logic                 SDA_IN,   // wire level
   input wire logic                 SDA_OUT,  // data value
   input wire logic                 SDA_OE,   // pull enable
   input wire logic [3:0]           ADDR_SEL, // address pins
   input wire logic                 WP_N,     // protect
   input wire logic [POTS*TAPS-1:0] TAP_SEL   // taps
);
   logic seen_q; // a start was seen since reset
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   // start flag; set before the device can see it, so the gate stays loose
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) seen_q <= 1'b0;
      else if (SCL && $fell(SDA_IN)) seen_q <= 1'b1;
   end
   sequence s_hold_on; SDA_OE[*8]; endsequence
   sequence s_hold_off; !SDA_OE[*8]; endsequence
   property p_drain; SDA_OUT == 1'b0; endproperty
   a_drain: assert property (p_drain) else $error("data value not low");
   property p_onehot;
      $onehot(TAP_SEL[63:0]) && $onehot(TAP_SEL[127:64]) && $onehot(TAP_SEL[191:128])
         && $onehot(TAP_SEL[255:192]);
   endproperty
   a_onehot: assert property (p_onehot) else $error("tap group not one-hot");
   property p_recall; $fell(SYS_RST) |-> ##[1:3] TAP_SEL == {POTS{64'h1 << 32}}; endproperty
   a_recall: assert property (p_recall) else $error("no recall at power-up");
   property p_scl_low; $changed(SDA_OE) |-> !$past(SCL, 1) && !$past(SCL, 2); endproperty
   a_scl_low: assert property (p_scl_low) else $error("sda moved with scl high");
   property p_hold_on; $rose(SDA_OE) |-> s_hold_on; endproperty
   a_hold_on: assert property (p_hold_on) else $error("pull shorter than a bit");
   property p_hold_off; $fell(SDA_OE) |-> s_hold_off; endproperty
   a_hold_off: assert property (p_hold_off) else $error("release shorter than a bit");
   property p_gate; !seen_q |-> !SDA_OE; endproperty
   a_gate: assert property (p_gate) else $error("answer before start");
   property p_tap_ack; $changed(TAP_SEL) && !$past(SYS_RST, 3) |-> SDA_OE; endproperty
   a_tap_ack: assert property (p_tap_ack) else $error("tap moved outside ack");
endmodule

bind quad_pot_wiper_serial_slave quad_pot_monitor #(.POTS(POTS), .TAPS(TAPS)) quad_pot_monitor_inst (
   .MCLK(MCLK), .SYS_RST(SYS_RST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .ADDR_SEL(ADDR_SEL), .WP_N(WP_N), .TAP_SEL(TAP_SEL));

// File: bench/quad_pot_bus_master.sv
// two-wire bus master model: owns SCL, pulls SDA low
// assumes a pull-up on SDA; SCL period is 8 block clocks
`timescale 1ns/1ps

module quad_pot_bus_master (
   input wire logic clk,    // timing base
   input wire logic sda,    // resolved wire level
   output logic     scl,    // serial clock
   output logic     sda_oe  // high while pulling low
);
   // idle bus; clock stands high outside frames
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic tk(input int n);
      repeat (n) @(negedge clk);
   endtask
   // data set mid-low, sampled mid-high
   task automatic bit_x(input logic b, output logic r);
      scl = 1'b0;
      tk(2);
      sda_oe = ~b;
      tk(2);
      scl = 1'b1;
      tk(2);
      r = sda;
      tk(2);
   endtask
   task automatic start_c();
      sda_oe = 1'b0;
      tk(4);
      sda_oe = 1'b1;
      tk(4);
   endtask
   task automatic stop_c();
      scl = 1'b0;
      tk(2);
      sda_oe = 1'b1;
      tk(2);
      scl = 1'b1;
      tk(4);
      sda_oe = 1'b0;
      tk(4);
   endtask
   // eight bits released after, ninth clock samples the ack
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   // read one byte, then answer with a not-acknowledge
   task automatic rbyte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(1'b1, r);
   endtask
endmodule

// File: bench/testbench.sv
// random register traffic against a model of the wipers and stored slots
// assumes the design package and the bus master model are compiled first
`timescale 1ns/1ps
`include "quad_pot_regs.svh"

module testbench;
   logic         mclk, sys_rst, scl, sda, m_oe, sda_out, sda_oe, wp_n;
   logic [3:0]   addr_sel;
   logic [255:0] tap_sel;
   int           err_count, comparisons, seed;
   logic [5:0]   wip [4];
   logic [5:0]   sto [4][4];
   assign sda = ~(sda_oe | m_oe); // pull-up wins when nobody pulls
   quad_pot_wiper_serial_slave quad_pot_wiper_serial_slave_inst (.MCLK(mclk), .SYS_RST(sys_rst),
      .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
      .WP_N(wp_n), .TAP_SEL(tap_sel));
   quad_pot_bus_master quad_pot_bus_master_inst (.clk(mclk), .sda(sda), .scl(scl), .sda_oe(m_oe));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_taps();
      for (int p = 0; p < 4; p++) chk(tap_sel[p*64 +: 64], 64'h1 << wip[p]);
   endtask
   // address, command, then a data byte out, a byte in, or nothing
   task automatic xact(input logic [7:0] a, c, d, output logic [7:0] r, output logic [2:0] ak);
      ak = 3'b000;
      r = 8'h00;
      quad_pot_bus_master_inst.start_c();
      quad_pot_bus_master_inst.wbyte(a, ak[2]);
      if (ak[2]) quad_pot_bus_master_inst.wbyte(c, ak[1]);
      if (ak[1] && c[7:4] inside {`QP_OP_WR_WIPER, `QP_OP_WR_STORED}) quad_pot_bus_master_inst.wbyte(d, ak[0]);
      if (ak[1] && c[7:4] inside {`QP_OP_RD_WIPER, `QP_OP_RD_STORED}) quad_pot_bus_master_inst.rbyte(r);
      quad_pot_bus_master_inst.stop_c();
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // a hang is cut short well after the tests should be done
   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      print_verdict();
   end
   initial begin
      logic [7:0] a, c, d, r;
      logic [2:0] ak;
      logic [1:0] pt, ix;
      seed = 32'hd1f6;
      err_count = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      wp_n = 1'b1;
      addr_sel = 4'($random(seed));
      a = {`QP_SLAVE_ID, addr_sel};
      foreach (sto[p, i]) sto[p][i] = `QP_STORED_RESET;
      foreach (wip[p]) wip[p] = `QP_STORED_RESET;
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      check_taps();
      $display("test recall done");
      // every opcode in turn, random pot, slot, data and protect level
      for (int n = 0; n < 40; n++) begin
         c = 8'($random(seed));
         c[7:4] = 4'h9 + 4'(n % 5);
         d = 8'($random(seed));
         wp_n = 1'($random(seed));
         pt = c[3:2];
         ix = c[1:0];
         xact(a, c, d, r, ak);
         case (c[7:4])
            `QP_OP_RD_WIPER: chk(r, {2'b00, wip[pt]});
            `QP_OP_WR_WIPER: wip[pt] = d[5:0];
            `QP_OP_RD_STORED: chk(r, {2'b00, sto[pt][ix]});
            `QP_OP_WR_STORED: if (wp_n) sto[pt][ix] = d[5:0];
            default: wip[pt] = sto[pt][ix];
         endcase
         chk(ak, c[7:4] inside {`QP_OP_WR_WIPER, `QP_OP_WR_STORED} ? 3'b111 : 3'b110);
         check_taps();
      end
      $display("test random traffic done");
      xact(a, 8'hac, 8'hff, r, ak);
      wip[3] = 6'h3f;
      check_taps();
      xact(a ^ 8'h01, 8'ha0, 8'h00, r, ak);
      chk(ak, 3'b000);
      xact(a ^ 8'h80, 8'ha0, 8'h00, r, ak);
      chk(ak, 3'b000);
      check_taps();
      $display("test address done");
      // unknown opcode is refused; a protected stored write is acked, content kept
      xact(a, 8'h15, 8'h00, r, ak);
      chk(ak, 3'b100);
      wp_n = 1'b0;
      xact(a, 8'hc5, 8'h2a, r, ak);
      chk(ak, 3'b111);
      xact(a, 8'hb5, 8'h00, r, ak);
      chk(r, {2'b00, sto[1][1]});
      $display("test refusal done");
      print_verdict();
   end
endmodule
